// ### plc_fb_pkg.sv
package plc_fb_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIME_BASE_10MS_NS = 10000000;
  localparam int TICK_10MS_CYCLES = (TIME_BASE_10MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] DECADE_LAST = 4'h9;
  localparam int VALUE_W = 16;

  localparam logic [7:0] OFFS_CTRL = 8'h00;
  localparam logic [7:0] OFFS_DELAY = 8'h04;
  localparam logic [7:0] OFFS_ONE_SHOT = 8'h08;
  localparam logic [7:0] OFFS_BLINK = 8'h0C;
  localparam logic [7:0] OFFS_SCHEDULE = 8'h10;
  localparam logic [7:0] OFFS_COUNT_SET = 8'h14;
  localparam logic [7:0] OFFS_COMPARE = 8'h18;
  localparam logic [7:0] OFFS_STATUS = 8'h1C;
  localparam logic [7:0] OFFS_COUNTS = 8'h20;

  localparam int CTRL_SET_PRIO = 0;
  localparam int CTRL_EDGE_LSB = 1;
  localparam int CTRL_OS_PRIO = 3;
  localparam int CTRL_DL_TB_LSB = 4;
  localparam int CTRL_OS_TB_LSB = 6;
  localparam int CTRL_FL_TB_LSB = 8;
  localparam int CTRL_EXPR_OP_LSB = 10;
  localparam int CTRL_EXPR_INV = 12;
  localparam int CTRL_USED_W = 13;
  localparam int HIGH_LSB = 16;
  localparam int REL_LSB = 16;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_mode_t;
  typedef enum logic [1:0] {TB_10MS, TB_100MS, TB_1S} time_base_t;
  typedef enum logic [1:0] {EXPR_AND, EXPR_OR, EXPR_XOR} expr_op_t;
  typedef enum logic [2:0] {REL_EQ, REL_GT, REL_GE, REL_LT, REL_LE, REL_NE} relation_t;

  typedef struct packed {
    logic and_q;
    logic or_q;
    logic nand_q;
    logic nor_q;
    logic not_q;
    logic xor_q;
    logic expr_q;
    logic latch_q;
    logic edge_q;
    logic toggle_q;
    logic delay_q;
    logic one_shot_q;
    logic blink_q;
    logic schedule_q;
    logic count_done_q;
    logic bidir_done_q;
    logic compare_q;
  } block_out_t;

  typedef struct packed {
    logic edge_in;
    logic toggle_in;
    logic one_shot_in;
    logic count_in;
    logic up_in;
    logic down_in;
    logic blink_en_in;
  } prev_in_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] delay_times;
    logic [31:0] one_shot_time;
    logic [31:0] blink_times;
    logic [31:0] schedule;
    logic [31:0] count_set;
    logic [31:0] compare_cfg;
    logic [31:0] rdata;
    logic [31:0] tick_cnt;
    logic [3:0] dec100;
    logic [3:0] dec1s;
    prev_in_t prev;
    logic [VALUE_W-1:0] dl_cnt;
    logic [VALUE_W-1:0] os_cnt;
    logic [VALUE_W-1:0] fl_cnt;
    logic [VALUE_W-1:0] ev_count;
    logic [VALUE_W-1:0] bd_count;
    block_out_t outs;
  } state_t;
endpackage : plc_fb_pkg

// ### plc_function_block_set.sv
`timescale 1ns/1ns
// How it works
// - and output high only when all four inputs are high
// - or output low only when all four inputs are low
// - not output is the complement of its one input
// - xor output high when its two inputs differ
// - nand output low only when all four inputs are high
// - nor output high only when all four inputs are low
// - basic gates take single bits only and have no settings
// - expression gate combines inputs by and, or, xor, optional not
// - latch goes high after set, low after reset
// - set and reset together follow priority bit, reset wins by default
// - edge pulse fires one cycle on rising, falling or both edges
// - toggle flips its output on every rising input edge
// - delay timer has separate on and off delay intervals
// - timers select 10 ms, 100 ms or 1 s per count
// - one-shot holds output for set duration, input priority optional
// - blink cycler alternates output with on and off durations
// - schedule switch compares time of day with on and off times
// - event counter counts edges, output high at set value
// - event counter clear input zeroes the count
// - bidir counter counts up and down, output high at set value
// - bidir preset forces count to set value
// - comparator tests value against configured relation
module plc_function_block_set #(
  parameter int TICK_CYCLES = plc_fb_pkg::TICK_10MS_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [3:0] gate_in,
  input wire logic not_in,
  input wire logic [1:0] xor_in,
  input wire logic [3:0] expr_in,
  input wire logic latch_set_in,
  input wire logic latch_reset_in,
  input wire logic edge_in,
  input wire logic toggle_in,
  input wire logic delay_in,
  input wire logic one_shot_in,
  input wire logic blink_en_in,
  input wire logic [15:0] tod_minutes_in,
  input wire logic count_in,
  input wire logic count_clear_in,
  input wire logic up_in,
  input wire logic down_in,
  input wire logic preset_in,
  input wire logic [15:0] compare_value_in,
  output logic and_out,
  output logic or_out,
  output logic nand_out,
  output logic nor_out,
  output logic not_out,
  output logic xor_out,
  output logic expr_out,
  output logic latch_out,
  output logic edge_out,
  output logic toggle_out,
  output logic delay_out,
  output logic one_shot_out,
  output logic blink_out,
  output logic schedule_out,
  output logic count_done_out,
  output logic bidir_done_out,
  output logic compare_out
);

  localparam int VW = plc_fb_pkg::VALUE_W;

  plc_fb_pkg::state_t st_reg;
  plc_fb_pkg::state_t st_next;
  logic t10;
  logic t100;
  logic t1s;
  logic [VW-1:0] on_min;
  logic [VW-1:0] off_min;
  logic [VW-1:0] limit;

  // unit tick for a selected time base
  function automatic logic unit_tick(input logic [1:0] tb, input logic a, input logic b, input logic c);
    case (tb)
      plc_fb_pkg::TB_10MS: unit_tick = a;
      plc_fb_pkg::TB_100MS: unit_tick = b;
      plc_fb_pkg::TB_1S: unit_tick = c;
      default: unit_tick = a;
    endcase
  endfunction : unit_tick

  // saturating step of a count
  function automatic logic [VW-1:0] step(input logic [VW-1:0] v, input logic up);
    if (up) begin
      step = (v == {VW{1'b1}}) ? v : VW'(v + 1'b1);
    end else begin
      step = (v == '0) ? v : VW'(v - 1'b1);
    end
  endfunction : step

  // prescaler ticks
  assign t10 = (st_reg.tick_cnt == 32'(TICK_CYCLES - 1));
  assign t100 = t10 && (st_reg.dec100 == plc_fb_pkg::DECADE_LAST);
  assign t1s = t100 && (st_reg.dec1s == plc_fb_pkg::DECADE_LAST);

  always_comb begin
    st_next = st_reg;
    on_min = '0;
    off_min = '0;
    limit = '0;

    // register writes
    if (wr_in) begin
      case (addr_in)
        plc_fb_pkg::OFFS_CTRL: st_next.ctrl = {19'h0, wdata_in[plc_fb_pkg::CTRL_USED_W-1:0]};
        plc_fb_pkg::OFFS_DELAY: st_next.delay_times = wdata_in;
        plc_fb_pkg::OFFS_ONE_SHOT: st_next.one_shot_time = {16'h0, wdata_in[15:0]};
        plc_fb_pkg::OFFS_BLINK: st_next.blink_times = wdata_in;
        plc_fb_pkg::OFFS_SCHEDULE: st_next.schedule = wdata_in;
        plc_fb_pkg::OFFS_COUNT_SET: st_next.count_set = wdata_in;
        plc_fb_pkg::OFFS_COMPARE: st_next.compare_cfg = {13'h0, wdata_in[18:0]};
        default: ;
      endcase
    end

    // read data for the next cycle only
    st_next.rdata = 32'h0000_0000;
    if (rd_in) begin
      case (addr_in)
        plc_fb_pkg::OFFS_CTRL: st_next.rdata = st_reg.ctrl;
        plc_fb_pkg::OFFS_DELAY: st_next.rdata = st_reg.delay_times;
        plc_fb_pkg::OFFS_ONE_SHOT: st_next.rdata = st_reg.one_shot_time;
        plc_fb_pkg::OFFS_BLINK: st_next.rdata = st_reg.blink_times;
        plc_fb_pkg::OFFS_SCHEDULE: st_next.rdata = st_reg.schedule;
        plc_fb_pkg::OFFS_COUNT_SET: st_next.rdata = st_reg.count_set;
        plc_fb_pkg::OFFS_COMPARE: st_next.rdata = st_reg.compare_cfg;
        plc_fb_pkg::OFFS_STATUS: st_next.rdata = 32'(st_reg.outs);
        plc_fb_pkg::OFFS_COUNTS: st_next.rdata = {st_reg.bd_count, st_reg.ev_count};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end

    // time base prescaler
    st_next.tick_cnt = t10 ? 32'h0000_0000 : st_reg.tick_cnt + 32'h0000_0001;
    if (t10) begin
      st_next.dec100 = (st_reg.dec100 == plc_fb_pkg::DECADE_LAST) ? 4'h0 : st_reg.dec100 + 4'h1;
    end
    if (t100) begin
      st_next.dec1s = (st_reg.dec1s == plc_fb_pkg::DECADE_LAST) ? 4'h0 : st_reg.dec1s + 4'h1;
    end

    // basic gates, bit inputs only, nothing to configure
    st_next.outs.and_q = &gate_in;
    st_next.outs.or_q = |gate_in;
    st_next.outs.not_q = ~not_in;
    st_next.outs.xor_q = xor_in[0] ^ xor_in[1];
    st_next.outs.nand_q = ~&gate_in;
    st_next.outs.nor_q = ~|gate_in;

    // expression gate
    case (st_reg.ctrl[plc_fb_pkg::CTRL_EXPR_OP_LSB +: 2])
      plc_fb_pkg::EXPR_AND: st_next.outs.expr_q = &expr_in;
      plc_fb_pkg::EXPR_OR: st_next.outs.expr_q = |expr_in;
      plc_fb_pkg::EXPR_XOR: st_next.outs.expr_q = ^expr_in;
      default: st_next.outs.expr_q = &expr_in;
    endcase
    st_next.outs.expr_q = st_next.outs.expr_q ^ st_reg.ctrl[plc_fb_pkg::CTRL_EXPR_INV];

    // set/reset latch
    if (latch_set_in && latch_reset_in) begin
      st_next.outs.latch_q = st_reg.ctrl[plc_fb_pkg::CTRL_SET_PRIO];
    end else if (latch_set_in) begin
      st_next.outs.latch_q = 1'b1;
    end else if (latch_reset_in) begin
      st_next.outs.latch_q = 1'b0;
    end

    // edge pulse against previous sample
    case (st_reg.ctrl[plc_fb_pkg::CTRL_EDGE_LSB +: 2])
      plc_fb_pkg::EDGE_RISE: st_next.outs.edge_q = edge_in && !st_reg.prev.edge_in;
      plc_fb_pkg::EDGE_FALL: st_next.outs.edge_q = !edge_in && st_reg.prev.edge_in;
      plc_fb_pkg::EDGE_BOTH: st_next.outs.edge_q = edge_in ^ st_reg.prev.edge_in;
      default: st_next.outs.edge_q = 1'b0;
    endcase

    // toggle
    if (toggle_in && !st_reg.prev.toggle_in) begin
      st_next.outs.toggle_q = ~st_reg.outs.toggle_q;
    end

    // delay timer
    if (delay_in == st_reg.outs.delay_q) begin
      st_next.dl_cnt = '0;
    end else begin
      limit = delay_in ? st_reg.delay_times[VW-1:0] : st_reg.delay_times[plc_fb_pkg::HIGH_LSB +: VW];
      if (st_reg.dl_cnt >= limit) begin
        st_next.outs.delay_q = delay_in;
        st_next.dl_cnt = '0;
      end else if (unit_tick(st_reg.ctrl[plc_fb_pkg::CTRL_DL_TB_LSB +: 2], t10, t100, t1s)) begin
        st_next.dl_cnt = step(st_reg.dl_cnt, 1'b1);
      end
    end

    // one-shot timer
    if (one_shot_in && !st_reg.prev.one_shot_in && !st_reg.outs.one_shot_q) begin
      st_next.outs.one_shot_q = 1'b1;
      st_next.os_cnt = '0;
    end else if (st_reg.outs.one_shot_q) begin
      if (st_reg.ctrl[plc_fb_pkg::CTRL_OS_PRIO] && !one_shot_in) begin
        st_next.outs.one_shot_q = 1'b0;
      end else if (st_reg.os_cnt >= st_reg.one_shot_time[VW-1:0]) begin
        st_next.outs.one_shot_q = 1'b0;
      end else if (unit_tick(st_reg.ctrl[plc_fb_pkg::CTRL_OS_TB_LSB +: 2], t10, t100, t1s)) begin
        st_next.os_cnt = step(st_reg.os_cnt, 1'b1);
      end
    end

    // blink cycler, starts in the on phase
    if (!blink_en_in) begin
      st_next.outs.blink_q = 1'b0;
      st_next.fl_cnt = '0;
    end else if (!st_reg.prev.blink_en_in) begin
      st_next.outs.blink_q = 1'b1;
      st_next.fl_cnt = '0;
    end else begin
      limit = st_reg.outs.blink_q ? st_reg.blink_times[VW-1:0] : st_reg.blink_times[plc_fb_pkg::HIGH_LSB +: VW];
      if (st_reg.fl_cnt >= limit) begin
        st_next.outs.blink_q = ~st_reg.outs.blink_q;
        st_next.fl_cnt = '0;
      end else if (unit_tick(st_reg.ctrl[plc_fb_pkg::CTRL_FL_TB_LSB +: 2], t10, t100, t1s)) begin
        st_next.fl_cnt = step(st_reg.fl_cnt, 1'b1);
      end
    end

    // schedule switch, window may wrap past midnight
    on_min = st_reg.schedule[VW-1:0];
    off_min = st_reg.schedule[plc_fb_pkg::HIGH_LSB +: VW];
    if (on_min <= off_min) begin
      st_next.outs.schedule_q = (tod_minutes_in >= on_min) && (tod_minutes_in < off_min);
    end else begin
      st_next.outs.schedule_q = (tod_minutes_in >= on_min) || (tod_minutes_in < off_min);
    end

    // event counter
    if (count_clear_in) begin
      st_next.ev_count = '0;
    end else if (count_in && !st_reg.prev.count_in) begin
      st_next.ev_count = step(st_reg.ev_count, 1'b1);
    end
    st_next.outs.count_done_q = (st_next.ev_count >= st_reg.count_set[VW-1:0]);

    // bidir counter
    if (preset_in) begin
      st_next.bd_count = st_reg.count_set[plc_fb_pkg::HIGH_LSB +: VW];
    end else if (up_in && !st_reg.prev.up_in && !(down_in && !st_reg.prev.down_in)) begin
      st_next.bd_count = step(st_reg.bd_count, 1'b1);
    end else if (down_in && !st_reg.prev.down_in && !(up_in && !st_reg.prev.up_in)) begin
      st_next.bd_count = step(st_reg.bd_count, 1'b0);
    end
    st_next.outs.bidir_done_q = (st_next.bd_count == st_reg.count_set[plc_fb_pkg::HIGH_LSB +: VW]);

    // comparator
    case (st_reg.compare_cfg[plc_fb_pkg::REL_LSB +: 3])
      plc_fb_pkg::REL_EQ: st_next.outs.compare_q = compare_value_in == st_reg.compare_cfg[VW-1:0];
      plc_fb_pkg::REL_GT: st_next.outs.compare_q = compare_value_in > st_reg.compare_cfg[VW-1:0];
      plc_fb_pkg::REL_GE: st_next.outs.compare_q = compare_value_in >= st_reg.compare_cfg[VW-1:0];
      plc_fb_pkg::REL_LT: st_next.outs.compare_q = compare_value_in < st_reg.compare_cfg[VW-1:0];
      plc_fb_pkg::REL_LE: st_next.outs.compare_q = compare_value_in <= st_reg.compare_cfg[VW-1:0];
      plc_fb_pkg::REL_NE: st_next.outs.compare_q = compare_value_in != st_reg.compare_cfg[VW-1:0];
      default: st_next.outs.compare_q = 1'b0;
    endcase

    // previous samples for edge detection
    st_next.prev = '{edge_in: edge_in, toggle_in: toggle_in, one_shot_in: one_shot_in,
                     count_in: count_in, up_in: up_in, down_in: down_in, blink_en_in: blink_en_in};
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
      st_reg.ctrl <= plc_fb_pkg::CTRL_RESET;
      st_reg.delay_times <= plc_fb_pkg::CFG_RESET;
      st_reg.count_set <= plc_fb_pkg::CFG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_out = st_reg.rdata;
  assign and_out = st_reg.outs.and_q;
  assign or_out = st_reg.outs.or_q;
  assign nand_out = st_reg.outs.nand_q;
  assign nor_out = st_reg.outs.nor_q;
  assign not_out = st_reg.outs.not_q;
  assign xor_out = st_reg.outs.xor_q;
  assign expr_out = st_reg.outs.expr_q;
  assign latch_out = st_reg.outs.latch_q;
  assign edge_out = st_reg.outs.edge_q;
  assign toggle_out = st_reg.outs.toggle_q;
  assign delay_out = st_reg.outs.delay_q;
  assign one_shot_out = st_reg.outs.one_shot_q;
  assign blink_out = st_reg.outs.blink_q;
  assign schedule_out = st_reg.outs.schedule_q;
  assign count_done_out = st_reg.outs.count_done_q;
  assign bidir_done_out = st_reg.outs.bidir_done_q;
  assign compare_out = st_reg.outs.compare_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  and_or_gate_a: assert property (rst_n_in |=> and_out == &$past(gate_in) && or_out == |$past(gate_in))
    else $error("and/or gate output wrong");
  not_gate_a: assert property (rst_n_in |=> not_out != $past(not_in))
    else $error("not gate output wrong");
  xor_gate_a: assert property ((xor_in[0] == xor_in[1]) |=> !xor_out)
    else $error("xor high with equal inputs");
  nand_nor_a: assert property (rst_n_in
                               |=> nand_out == !(&$past(gate_in)) && nor_out == !(|$past(gate_in)))
    else $error("nand/nor output wrong");
  latch_prio_a: assert property (latch_set_in && latch_reset_in && !st_reg.ctrl[plc_fb_pkg::CTRL_SET_PRIO]
                                 |=> !latch_out)
    else $error("reset priority lost");
  latch_hold_a: assert property (!latch_set_in && !latch_reset_in |=> $stable(latch_out))
    else $error("latch changed without input");
  edge_rise_a: assert property ($rose(edge_in) && st_reg.ctrl[2:1] == plc_fb_pkg::EDGE_RISE
                                |=> edge_out ##1 (!edge_out || $rose(edge_in)))
    else $error("rising edge pulse wrong");
  toggle_flip_a: assert property ($rose(toggle_in) |=> toggle_out != $past(toggle_out))
    else $error("toggle did not flip");
  count_clear_a: assert property (count_clear_in |=> st_reg.ev_count == '0)
    else $error("counter not cleared");
  bidir_preset_a: assert property (preset_in |=> bidir_done_out && st_reg.bd_count == $past(st_reg.count_set[31:16]))
    else $error("preset did not load set value");
  delay_zero_a: assert property (st_reg.delay_times == 32'h0000_0000 && $stable(delay_in) [*2]
                                 |=> delay_out == $past(delay_in, 2))
    else $error("zero delay not followed");

  latch_both_c: cover property (latch_set_in && latch_reset_in);
  delay_rise_c: cover property ($rose(delay_out));
  one_shot_c: cover property ($rose(one_shot_out) ##[1:1000] $fell(one_shot_out));
  blink_c: cover property ($rose(blink_out) ##[1:1000] $fell(blink_out));

endmodule : plc_function_block_set

// ### plc_function_block_set_test.sv
`timescale 1ns/1ns
module plc_function_block_set_test;
  localparam int TICKS = 4;
  typedef struct packed {logic [3:0] g; logic n; logic [1:0] x; logic [5:0] e;} gate_row_t;
  logic clk_in, rst_n_in, wr_in, rd_in, not_in, latch_set_in, latch_reset_in, edge_in, toggle_in;
  logic delay_in, one_shot_in, blink_en_in, count_in, count_clear_in, up_in, down_in, preset_in;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, rd_val;
  logic [3:0] gate_in, expr_in, e;
  logic [1:0] xor_in;
  logic [15:0] tod_minutes_in, compare_value_in;
  logic and_out, or_out, nand_out, nor_out, not_out, xor_out, expr_out, latch_out, edge_out;
  logic toggle_out, delay_out, one_shot_out, blink_out, schedule_out, count_done_out;
  logic bidir_done_out, compare_out, x;
  int failures = 0;
  int total_checks = 0;
  gate_row_t rows [5] = '{'{4'h0, 1'b0, 2'h0, 6'h0E}, '{4'hF, 1'b1, 2'h3, 6'h30},
    '{4'h7, 1'b0, 2'h1, 6'h1B}, '{4'h8, 1'b1, 2'h2, 6'h19}, '{4'hE, 1'b0, 2'h0, 6'h1A}};

  plc_function_block_set #(.TICK_CYCLES(TICKS)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .gate_in(gate_in), .not_in(not_in), .xor_in(xor_in), .expr_in(expr_in), .latch_set_in(latch_set_in),
    .latch_reset_in(latch_reset_in), .edge_in(edge_in), .toggle_in(toggle_in), .delay_in(delay_in),
    .one_shot_in(one_shot_in), .blink_en_in(blink_en_in), .tod_minutes_in(tod_minutes_in),
    .count_in(count_in), .count_clear_in(count_clear_in), .up_in(up_in), .down_in(down_in),
    .preset_in(preset_in), .compare_value_in(compare_value_in), .and_out(and_out), .or_out(or_out),
    .nand_out(nand_out), .nor_out(nor_out), .not_out(not_out), .xor_out(xor_out), .expr_out(expr_out),
    .latch_out(latch_out), .edge_out(edge_out), .toggle_out(toggle_out), .delay_out(delay_out),
    .one_shot_out(one_shot_out), .blink_out(blink_out), .schedule_out(schedule_out),
    .count_done_out(count_done_out), .bidir_done_out(bidir_done_out), .compare_out(compare_out));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task results;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task settle;
    @(posedge clk_in);
    #1;
  endtask : settle

  task reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : reg_write

  task reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : reg_read

  function automatic logic pick(input int s);
    case (s)
      0: pick = delay_out;
      1: pick = one_shot_out;
      default: pick = blink_out;
    endcase
  endfunction : pick

  task wait_for(input int s, input logic lvl, input int lim);
    for (int i = 0; i < lim && pick(s) !== lvl; i++) begin
      settle();
    end
    check("timer output", {31'h0, pick(s)}, {31'h0, lvl});
    if (pick(s) !== lvl) results();
  endtask : wait_for

  task drive_latch(input logic s, input logic r, input logic exp);
    @(posedge clk_in);
    latch_set_in <= s;
    latch_reset_in <= r;
    settle();
    check("latch_out", {31'h0, latch_out}, {31'h0, exp});
  endtask : drive_latch

  task edge_step(input logic v, input logic exp);
    @(posedge clk_in);
    edge_in <= v;
    settle();
    check("edge pulse", {31'h0, edge_out}, {31'h0, exp});
    settle();
    check("edge after pulse", {31'h0, edge_out}, 32'h0);
  endtask : edge_step

  task pulse(input logic [2:0] w);
    @(posedge clk_in);
    {count_in, up_in, down_in} <= w;
    @(posedge clk_in);
    {count_in, up_in, down_in} <= 3'h0;
    settle();
  endtask : pulse

  initial begin
    {addr_in, wdata_in, wr_in, rd_in, gate_in, not_in, xor_in, expr_in, latch_set_in, latch_reset_in} = '0;
    {edge_in, toggle_in, delay_in, one_shot_in, blink_en_in, tod_minutes_in, count_in} = '0;
    {count_clear_in, up_in, down_in, preset_in, compare_value_in, rst_n_in} = '0;
    repeat (15) @(posedge clk_in);
    #1;
    check("outputs in reset", {26'h0, and_out, nand_out, nor_out, not_out, latch_out, bidir_done_out}, 32'h0);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    settle();
    check("bidir done at zero", {31'h0, bidir_done_out}, 32'h1);
    reg_read(plc_fb_pkg::OFFS_CTRL, rd_val);
    check("ctrl reset", rd_val, 32'h0);
    reg_read(plc_fb_pkg::OFFS_STATUS, rd_val);
    check("status after reset", rd_val, 32'h0000_7007);
    reg_write(8'h40, 32'h1234_5678);
    reg_read(8'h40, rd_val);
    check("unmapped read", rd_val, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk_in);
      gate_in <= rows[i].g;
      not_in <= rows[i].n;
      xor_in <= rows[i].x;
      settle();
      check("gates", {26'h0, and_out, or_out, nand_out, nor_out, not_out, xor_out}, {26'h0, rows[i].e});
    end
    $display("test gates done");
    for (int op = 0; op < 3; op++) begin
      for (int k = 0; k < 4; k++) begin
        reg_write(plc_fb_pkg::OFFS_CTRL, (32'(op) << 10) | (32'(k % 2) << 12));
        e = (k < 2) ? 4'hB : 4'hF;
        @(posedge clk_in);
        expr_in <= e;
        settle();
        x = ((op == 0) ? &e : (op == 1) ? |e : ^e) ^ (k % 2);
        check("expr_out", {31'h0, expr_out}, {31'h0, x});
      end
    end
    $display("test expression done");
    reg_write(plc_fb_pkg::OFFS_CTRL, 32'h0);
    drive_latch(1'b1, 1'b0, 1'b1);
    drive_latch(1'b0, 1'b0, 1'b1);
    drive_latch(1'b0, 1'b1, 1'b0);
    drive_latch(1'b1, 1'b1, 1'b0);
    reg_write(plc_fb_pkg::OFFS_CTRL, 32'h1);
    drive_latch(1'b1, 1'b1, 1'b1);
    drive_latch(1'b0, 1'b0, 1'b1);
    $display("test latch done");
    for (int m = 0; m < 3; m++) begin
      reg_write(plc_fb_pkg::OFFS_CTRL, 32'(m) << 1);
      edge_step(1'b1, m != 1);
      edge_step(1'b0, m != 0);
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      toggle_in <= 1'b1;
      settle();
      @(posedge clk_in);
      toggle_in <= 1'b0;
      settle();
      check("toggle_out", {31'h0, toggle_out}, {31'h0, k == 0});
    end
    $display("test edges done");
    reg_write(plc_fb_pkg::OFFS_COUNT_SET, 32'h0002_0003);
    for (int k = 1; k <= 3; k++) begin
      pulse(3'h4);
      settle();
      check("count_done_out", {31'h0, count_done_out}, {31'h0, k == 3});
    end
    reg_read(plc_fb_pkg::OFFS_COUNTS, rd_val);
    check("counts", rd_val, 32'h0000_0003);
    @(posedge clk_in);
    count_clear_in <= 1'b1;
    count_in <= 1'b1;
    settle();
    @(posedge clk_in);
    count_clear_in <= 1'b0;
    count_in <= 1'b0;
    settle();
    check("count cleared", {31'h0, count_done_out}, 32'h0);
    check("bidir below set", {31'h0, bidir_done_out}, 32'h0);
    pulse(3'h2);
    pulse(3'h2);
    check("bidir up", {31'h0, bidir_done_out}, 32'h1);
    pulse(3'h1);
    check("bidir down", {31'h0, bidir_done_out}, 32'h0);
    @(posedge clk_in);
    preset_in <= 1'b1;
    settle();
    @(posedge clk_in);
    preset_in <= 1'b0;
    settle();
    check("bidir preset", {31'h0, bidir_done_out}, 32'h1);
    reg_read(plc_fb_pkg::OFFS_COUNTS, rd_val);
    check("counts after preset", rd_val, 32'h0002_0000);
    $display("test counters done");
    for (int r = 0; r < 6; r++) begin
      reg_write(plc_fb_pkg::OFFS_COMPARE, (32'(r) << 16) | 32'h0000_000A);
      for (int v = 9; v <= 11; v++) begin
        @(posedge clk_in);
        compare_value_in <= 16'(v);
        settle();
        x = (r == 0) ? v == 10 : (r == 1) ? v > 10 : (r == 2) ? v >= 10 : (r == 3) ? v < 10 : (r == 4) ? v <= 10 : v != 10;
        check("compare_out", {31'h0, compare_out}, {31'h0, x});
      end
    end
    reg_write(plc_fb_pkg::OFFS_SCHEDULE, 32'h00C8_0064);
    @(posedge clk_in);
    tod_minutes_in <= 16'h0096;
    settle();
    check("schedule inside", {31'h0, schedule_out}, 32'h1);
    @(posedge clk_in);
    tod_minutes_in <= 16'h00FA;
    settle();
    check("schedule outside", {31'h0, schedule_out}, 32'h0);
    reg_write(plc_fb_pkg::OFFS_SCHEDULE, 32'h0064_00C8);
    settle();
    check("schedule wrapped", {31'h0, schedule_out}, 32'h1);
    $display("test compare done");
    reg_write(plc_fb_pkg::OFFS_CTRL, 32'h0000_0040);
    reg_write(plc_fb_pkg::OFFS_DELAY, 32'h0003_0003);
    @(posedge clk_in);
    delay_in <= 1'b1;
    settle();
    check("delay early", {31'h0, delay_out}, 32'h0);
    wait_for(0, 1'b1, 20);
    @(posedge clk_in);
    delay_in <= 1'b0;
    settle();
    check("delay hold", {31'h0, delay_out}, 32'h1);
    wait_for(0, 1'b0, 20);
    reg_write(plc_fb_pkg::OFFS_DELAY, 32'h0000_0000);
    @(posedge clk_in);
    delay_in <= 1'b1;
    repeat (2) settle();
    check("zero delay", {31'h0, delay_out}, 32'h1);
    reg_write(plc_fb_pkg::OFFS_ONE_SHOT, 32'h0000_0002);
    @(posedge clk_in);
    one_shot_in <= 1'b1;
    @(posedge clk_in);
    one_shot_in <= 1'b0;
    #1;
    wait_for(1, 1'b1, 4);
    repeat (30) settle();
    check("one shot held", {31'h0, one_shot_out}, 32'h1);
    wait_for(1, 1'b0, 60);
    reg_write(plc_fb_pkg::OFFS_CTRL, 32'h0000_0048);
    @(posedge clk_in);
    one_shot_in <= 1'b1;
    repeat (3) settle();
    check("one shot input held", {31'h0, one_shot_out}, 32'h1);
    @(posedge clk_in);
    one_shot_in <= 1'b0;
    repeat (2) settle();
    check("one shot input priority", {31'h0, one_shot_out}, 32'h0);
    reg_write(plc_fb_pkg::OFFS_BLINK, 32'h0002_0002);
    @(posedge clk_in);
    blink_en_in <= 1'b1;
    settle();
    check("blink start", {31'h0, blink_out}, 32'h1);
    wait_for(2, 1'b0, 16);
    wait_for(2, 1'b1, 16);
    $display("test timers done");
    results();
  end
endmodule : plc_function_block_set_test
